// ### tcr_pkg.sv
// Shared constants for the timer channel register and prescaler block
package tcr_pkg;
    localparam int NUM_CH = 6;
    localparam int IDX_W = 6;
    localparam int DAT_W = 8;
    localparam int CNT_W = 16;
    // Register indices; the byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_MAIN_SC = 6'h20;
    localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 6'h38;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 6'h39;
    localparam logic [IDX_W-1:0] IDX_SC [NUM_CH] = '{6'h26, 6'h29, 6'h2C, 6'h2F, 6'h32, 6'h35};
    localparam logic [IDX_W-1:0] IDX_HI [NUM_CH] = '{6'h27, 6'h2A, 6'h2D, 6'h30, 6'h33, 6'h36};
    localparam logic [IDX_W-1:0] IDX_LO [NUM_CH] = '{6'h28, 6'h2B, 6'h2E, 6'h31, 6'h34, 6'h37};
    // Channel status/control fields
    localparam int SC_FLAG = 7;
    localparam int SC_IE = 6;
    localparam int SC_LINK = 5;
    localparam int SC_FUNC_A = 4;
    localparam int SC_ELS_HI = 3;
    localparam int SC_ELS_LO = 2;
    localparam int SC_TOV = 1;
    localparam int SC_MAX = 0;
    localparam logic [DAT_W-1:0] SC_RESET = 8'h00;
    localparam logic [DAT_W-1:0] ODD_SC_MASK = 8'hDF;
    // Main status/control: clock source select in bits 2..0
    localparam int CSS_W = 3;
    localparam logic [CSS_W-1:0] CSS_RESET = 3'h0;
    localparam logic [CSS_W-1:0] CSS_EXTERNAL = 3'h7;
    localparam int DIV_W = 6;
    localparam logic [DIV_W:0] DIV_ONE = 7'h01;
    localparam logic [DIV_W-1:0] DIV_RESET = 6'h00;
    localparam logic [DIV_W-1:0] DIV_STEP = 6'h01;
    localparam logic [NUM_CH-1:0] IRQ_RESET = 6'h00;
    localparam logic [31:0] WB_ZERO = 32'h00000000;
endpackage

// ### tcr_top.sv
// Timer channel registers, input capture flags and counter clock prescaler
module tcr_top #(
    parameter int NUM_CH = tcr_pkg::NUM_CH,
    parameter int CNT_W = tcr_pkg::CNT_W
) (
    input wire logic I_CLK_SYS,
    input wire logic I_RST,
    input wire logic I_CE,
    input wire logic I_WB_CYC,
    input wire logic I_WB_STB,
    input wire logic I_WB_WE,
    input wire logic [7:0] I_WB_ADR,
    input wire logic [3:0] I_WB_SEL,
    input wire logic [31:0] I_WB_DAT,
    input wire logic [CNT_W-1:0] I_COUNT,
    input wire logic [NUM_CH-1:0] I_CH_PIN,
    input wire logic I_EXT_COUNT_CLOCK_PIN,
    output logic [31:0] O_WB_DAT,
    output logic O_WB_ACK,
    output logic O_COUNT_TICK,
    output logic [NUM_CH/2-1:0] O_BUFFERED_LINK,
    output logic O_IRQ
);
    logic ack_q;
    logic [31:0] rdat_q;
    logic [31:0] rdat_d;
    logic tick_q;
    logic irq_q;
    logic [NUM_CH/2-1:0] link_q;
    logic [tcr_pkg::CSS_W-1:0] css_q;
    logic [tcr_pkg::DIV_W-1:0] div_cnt_q;
    logic [tcr_pkg::DIV_W-1:0] div_mask;
    logic ext_s1_q;
    logic ext_s2_q;
    logic ext_s3_q;
    logic tick_d;
    logic [7:0] sc_q [NUM_CH];
    logic [7:0] hi_q [NUM_CH];
    logic [7:0] lo_q [NUM_CH];
    logic [NUM_CH-1:0] pin_prev_q;
    logic [NUM_CH-1:0] cap_ev;
    logic [NUM_CH-1:0] irq_st_q;
    logic [NUM_CH-1:0] irq_mask_q;
    logic req;
    logic wr;
    logic [tcr_pkg::IDX_W-1:0] idx;
    logic [7:0] wdat;

    assign req = I_WB_CYC && I_WB_STB;
    // Write lands on the edge where the master samples ack
    assign wr = req && ack_q && I_WB_WE && I_WB_SEL[0];
    assign idx = I_WB_ADR[7:2];
    assign wdat = I_WB_DAT[7:0];

    // Bus answer: one wait state, read data registered with ack
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            ack_q <= 1'b0;
            rdat_q <= tcr_pkg::WB_ZERO;
        end else if (I_CE) begin
            ack_q <= req && !ack_q;
            rdat_q <= rdat_d;
        end
    end

    always_comb begin
        rdat_d = tcr_pkg::WB_ZERO;
        if (idx == tcr_pkg::IDX_MAIN_SC) begin
            rdat_d[tcr_pkg::CSS_W-1:0] = css_q;
        end
        if (idx == tcr_pkg::IDX_IRQ_STATUS) begin
            rdat_d[NUM_CH-1:0] = irq_st_q;
        end
        if (idx == tcr_pkg::IDX_IRQ_MASK) begin
            rdat_d[NUM_CH-1:0] = irq_mask_q;
        end
        for (int i = 0; i < NUM_CH; i++) begin
            if (idx == tcr_pkg::IDX_SC[i]) begin
                rdat_d[7:0] = sc_q[i];
            end
            if (idx == tcr_pkg::IDX_HI[i]) begin
                rdat_d[7:0] = hi_q[i];
            end
            if (idx == tcr_pkg::IDX_LO[i]) begin
                rdat_d[7:0] = lo_q[i];
            end
        end
    end

    // Clock source select register
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            css_q <= tcr_pkg::CSS_RESET;
        end else if (I_CE && wr && idx == tcr_pkg::IDX_MAIN_SC) begin
            css_q <= wdat[tcr_pkg::CSS_W-1:0];
        end
    end

    // Free-running divider; rate n ticks when the low n bits are all ones
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            div_cnt_q <= tcr_pkg::DIV_RESET;
        end else if (I_CE) begin
            div_cnt_q <= div_cnt_q + tcr_pkg::DIV_STEP;
        end
    end

    // Three stages: two to synchronise, the third only for edge detection
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_s3_q <= 1'b0;
        end else if (I_CE) begin
            ext_s1_q <= I_EXT_COUNT_CLOCK_PIN;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
        end
    end

    always_comb begin
        div_mask = tcr_pkg::DIV_W'((tcr_pkg::DIV_ONE << css_q) - tcr_pkg::DIV_ONE);
        if (css_q == tcr_pkg::CSS_EXTERNAL) begin
            tick_d = ext_s2_q && !ext_s3_q;
        end else begin
            tick_d = (div_cnt_q & div_mask) == div_mask;
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            tick_q <= 1'b0;
        end else if (I_CE) begin
            tick_q <= tick_d;
        end else begin
            tick_q <= 1'b0;
        end
    end

    // Capture edge detection per channel
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            pin_prev_q <= '0;
        end else if (I_CE) begin
            pin_prev_q <= I_CH_PIN;
        end
    end

    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            logic rise;
            logic fall;
            logic is_cap;
            logic odd_idle;
            rise = I_CH_PIN[i] && !pin_prev_q[i];
            fall = !I_CH_PIN[i] && pin_prev_q[i];
            is_cap = !sc_q[i][tcr_pkg::SC_FUNC_A] && !sc_q[i][tcr_pkg::SC_LINK];
            // Odd partner of a linked even channel does nothing
            odd_idle = (i % 2 == 1) && sc_q[i - (i % 2)][tcr_pkg::SC_LINK];
            cap_ev[i] = is_cap && !odd_idle
                && ((sc_q[i][tcr_pkg::SC_ELS_HI] && fall) || (sc_q[i][tcr_pkg::SC_ELS_LO] && rise));
        end
    end

    // Value pairs carry no reset: contents are undefined until written or captured
    always_ff @(posedge I_CLK_SYS) begin
        if (I_CE) begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (cap_ev[i]) begin
                    hi_q[i] <= I_COUNT[15:8];
                    lo_q[i] <= I_COUNT[7:0];
                end else if (wr && idx == tcr_pkg::IDX_HI[i]) begin
                    hi_q[i] <= wdat;
                end else if (wr && idx == tcr_pkg::IDX_LO[i]) begin
                    lo_q[i] <= wdat;
                end
            end
        end
    end

    // Status/control: flag is set by capture and cleared by writing zero; set wins
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            for (int i = 0; i < NUM_CH; i++) begin
                sc_q[i] <= tcr_pkg::SC_RESET;
            end
        end else if (I_CE) begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (wr && idx == tcr_pkg::IDX_SC[i]) begin
                    sc_q[i][6:0] <= (i % 2 == 1) ? (wdat[6:0] & tcr_pkg::ODD_SC_MASK[6:0])
                        : wdat[6:0];
                    if (!wdat[tcr_pkg::SC_FLAG]) begin
                        sc_q[i][tcr_pkg::SC_FLAG] <= 1'b0;
                    end
                end
                if (cap_ev[i]) begin
                    sc_q[i][tcr_pkg::SC_FLAG] <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            link_q <= '0;
        end else if (I_CE) begin
            for (int p = 0; p < NUM_CH / 2; p++) begin
                link_q[p] <= sc_q[2 * p][tcr_pkg::SC_LINK];
            end
        end
    end

    // Interrupt status is write-one-to-clear; a capture in the same cycle wins
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            irq_st_q <= tcr_pkg::IRQ_RESET;
            irq_mask_q <= tcr_pkg::IRQ_RESET;
            irq_q <= 1'b0;
        end else if (I_CE) begin
            if (wr && idx == tcr_pkg::IDX_IRQ_STATUS) begin
                irq_st_q <= (irq_st_q & ~wdat[NUM_CH-1:0]) | cap_ev;
            end else begin
                irq_st_q <= irq_st_q | cap_ev;
            end
            if (wr && idx == tcr_pkg::IDX_IRQ_MASK) begin
                irq_mask_q <= wdat[NUM_CH-1:0];
            end
            irq_q <= |(irq_st_q & irq_mask_q);
        end
    end

    assign O_WB_ACK = ack_q;
    assign O_WB_DAT = rdat_q;
    assign O_COUNT_TICK = tick_q;
    assign O_BUFFERED_LINK = link_q;
    assign O_IRQ = irq_q;

    sequence req_fresh_s;
        I_CE && req && !ack_q;
    endsequence

    sequence ack_pulse_s;
        ack_q ##1 !ack_q;
    endsequence

    bus_ack_pulse_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        req_fresh_s |=> ack_q) else $error("ack did not follow request");
    ack_single_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        (I_CE && ack_q) |=> !ack_q) else $error("ack longer than one cycle");
    tick_div_one_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        (I_CE && css_q == 3'h0) |=> tick_q) else $error("divide by one missed a tick");
    tick_source_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        (I_CE && css_q == 3'h7 && !(ext_s2_q && !ext_s3_q)) |=> !tick_q)
        else $error("external source ticked without edge");
    capture_copy_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        (I_CE && cap_ev[3]) |=> {hi_q[3], lo_q[3]} == $past(I_COUNT))
        else $error("capture did not copy counter");
    flag_set_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        (I_CE && cap_ev[1]) |=> sc_q[1][7]) else $error("capture did not set flag");
    odd_bit_zero_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        !sc_q[1][5] && !sc_q[3][5] && !sc_q[5][5]) else $error("odd link bit set");
    reset_clear_a: assert property (@(posedge I_CLK_SYS)
        I_RST |=> sc_q[2] == 8'h00 && css_q == 3'h0) else $error("reset left state");
    irq_level_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        (I_CE && |(irq_st_q & irq_mask_q)) ##1 I_CE |-> irq_q)
        else $error("interrupt not raised");
    link_idle_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        sc_q[0][5] |-> !cap_ev[1]) else $error("linked odd channel captured");
    read_cycle_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        (req_fresh_s ##1 I_CE) |-> ack_pulse_s) else $error("read cycle malformed");

    // Software writes and a channel 3 rising edge; a capture in the same cycle overrides the writes, so it is excluded
    sequence hi3_write_s;
        I_CE && wr && idx == tcr_pkg::IDX_HI[3] && !cap_ev[3];
    endsequence

    sequence sc3_zero_write_s;
        I_CE && wr && idx == tcr_pkg::IDX_SC[3] && !wdat[tcr_pkg::SC_FLAG] && !cap_ev[3];
    endsequence

    sequence sc0_one_write_s;
        I_CE && wr && idx == tcr_pkg::IDX_SC[0] && wdat[tcr_pkg::SC_FLAG]
            && !sc_q[0][tcr_pkg::SC_FLAG] && !cap_ev[0];
    endsequence

    sequence rise3_armed_s;
        I_CE && sc_q[3][tcr_pkg::SC_ELS_LO] && !sc_q[3][tcr_pkg::SC_FUNC_A]
            && !sc_q[2][tcr_pkg::SC_LINK] && I_CH_PIN[3] && !pin_prev_q[3];
    endsequence

    value_write_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        hi3_write_s |=> hi_q[3] == $past(wdat)) else $error("value byte write lost");
    flag_clear_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        sc3_zero_write_s |=> !sc_q[3][tcr_pkg::SC_FLAG]) else $error("flag not cleared");
    flag_no_set_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        sc0_one_write_s |=> !sc_q[0][tcr_pkg::SC_FLAG]) else $error("written one set flag");
    odd_read_zero_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        (I_CE && req && idx == tcr_pkg::IDX_SC[5]) |=> !rdat_q[tcr_pkg::SC_LINK])
        else $error("odd link bit read as one");
    rise_capture_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        rise3_armed_s |=> sc_q[3][tcr_pkg::SC_FLAG] && lo_q[3] == $past(I_COUNT[7:0]))
        else $error("rising edge not captured");
    link_out_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        I_CE |=> O_BUFFERED_LINK[0] == $past(sc_q[0][tcr_pkg::SC_LINK]))
        else $error("link output stale");

    // Interrupt bookkeeping; the output lags the status by one cycle
    irq_set_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        (I_CE && cap_ev[1]) |=> irq_st_q[1]) else $error("interrupt status not set");
    irq_clear_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        (I_CE && wr && idx == tcr_pkg::IDX_IRQ_STATUS && wdat[1] && !cap_ev[1])
        |=> !irq_st_q[1])
        else $error("interrupt status not cleared");
    irq_quiet_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        (I_CE && !(|(irq_st_q & irq_mask_q))) |=> !irq_q)
        else $error("interrupt without cause");

    // Prescaler, synchroniser and clock enable
    sync_chain_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        I_CE |=> ext_s2_q == $past(ext_s1_q)) else $error("synchroniser skipped a stage");
    ce_freeze_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        !I_CE |=> $stable(css_q) && $stable(div_cnt_q) && !tick_q)
        else $error("state moved while clock enable low");
    div_sixtyfour_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        (I_CE && css_q == 3'h6 && div_cnt_q != 6'h3F) |=> !tick_q)
        else $error("slowest rate ticked early");

    // Bus read data and refused writes
    sel_read_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        (I_CE && req && !ack_q && idx == tcr_pkg::IDX_MAIN_SC)
        |=> O_WB_DAT[tcr_pkg::CSS_W-1:0] == $past(css_q))
        else $error("select readback wrong");
    unmapped_zero_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        (I_CE && req && idx == 6'h3F) |=> O_WB_DAT == tcr_pkg::WB_ZERO)
        else $error("unmapped read not zero");
    lane_ignored_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        (I_CE && req && I_WB_WE && !I_WB_SEL[0] && !cap_ev[0]) |=> $stable(lo_q[0]))
        else $error("write without lane landed");
endmodule

// ### timer_channel_regs_prescaler_tb_top.sv
// Self-checking bench for the timer channel register and prescaler block
module timer_channel_regs_prescaler_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [5:0] idx; logic [7:0] wd; logic [7:0] ex;} tcr_row_type;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hF;
    logic [31:0] wdat = 32'h00000000;
    logic [15:0] cnt = 16'h0000;
    logic [5:0] pin = 6'h00;
    logic ext = 1'b0;
    logic [31:0] rdat;
    logic ack;
    logic tick;
    logic [2:0] link;
    logic irq;
    int fails = 0;
    int cmp_count = 0;
    int n;
    logic hit;
    logic [7:0] exp_lo;
    logic [7:0] exp_hi;
    logic [7:0] junk;
    // Odd control bit 5 reads 0, flag ignores a written one, unmapped reads 0
    tcr_row_type rows [20] = '{
        '{6'h20, 8'hFF, 8'h07}, '{6'h26, 8'hFF, 8'h7F}, '{6'h29, 8'hFF, 8'h5F},
        '{6'h2C, 8'hFF, 8'h7F}, '{6'h2F, 8'hFF, 8'h5F}, '{6'h32, 8'hFF, 8'h7F},
        '{6'h35, 8'hFF, 8'h5F}, '{6'h27, 8'hA5, 8'hA5}, '{6'h28, 8'h5A, 8'h5A},
        '{6'h2A, 8'h01, 8'h01}, '{6'h2B, 8'h80, 8'h80}, '{6'h2D, 8'hFF, 8'hFF},
        '{6'h2E, 8'h00, 8'h00}, '{6'h30, 8'h3C, 8'h3C}, '{6'h31, 8'hC3, 8'hC3},
        '{6'h33, 8'h96, 8'h96}, '{6'h34, 8'h69, 8'h69}, '{6'h36, 8'h0F, 8'h0F},
        '{6'h37, 8'hF0, 8'hF0}, '{6'h3F, 8'hAA, 8'h00}};

    always #10 clk = ~clk;

    tcr_top DUT (
        .I_CLK_SYS(clk), .I_RST(rst), .I_CE(ce), .I_WB_CYC(cyc), .I_WB_STB(stb),
        .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .I_COUNT(cnt),
        .I_CH_PIN(pin), .I_EXT_COUNT_CLOCK_PIN(ext), .O_WB_DAT(rdat), .O_WB_ACK(ack),
        .O_COUNT_TICK(tick), .O_BUFFERED_LINK(link), .O_IRQ(irq)
    );

    task automatic chk8(input string nm, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic chkc(input string nm, input int exp, input int got);
        cmp_count++;
        if (got != exp) begin
            fails++;
            $display("BAD %s expected %0d seen %0d", nm, exp, got);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Classic cycle; the request holds until ack is seen at a rising edge
    task automatic wb(input logic w, input logic [5:0] idx, input logic [7:0] d,
                      input logic [3:0] s, output logic [7:0] q);
        int k;
        k = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= s;
        adr <= {idx, 2'h0};
        wdat <= {24'h000000, d};
        @(posedge clk);
        while (ack !== 1'b1 && k < 20) begin
            k++;
            @(posedge clk);
        end
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (ack !== 1'b1) begin
            fails++;
            $display("BAD bus ack expected 1 seen none");
            wrap_up();
        end
    endtask

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        logic [7:0] q;
        wb(1'b1, idx, d, 4'hF, q);
    endtask

    task automatic rd(input string nm, input logic [5:0] idx, input logic [7:0] exp);
        logic [7:0] q;
        wb(1'b0, idx, 8'h00, 4'hF, q);
        chk8(nm, exp, q);
    endtask

    // Window of samples is a multiple of every divide ratio, so phase does not matter
    task automatic count_ticks(input int cycles, input logic drive_ext, output int c);
        c = 0;
        for (int k = 0; k < cycles; k++) begin
            @(posedge clk);
            if (tick === 1'b1) c++;
            if (drive_ext) ext <= (k % 8) < 4 && k < 64;
        end
    endtask

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++) rd("sc reset", tcr_pkg::IDX_SC[i], 8'h00);
        rd("irq status reset", tcr_pkg::IDX_IRQ_STATUS, 8'h00);
        chk8("link reset", {5'h00, link}, 8'h00);
        $display("test reset done");
        foreach (rows[i]) begin
            wr(rows[i].idx, rows[i].wd);
            rd("row readback", rows[i].idx, rows[i].ex);
        end
        repeat (2) @(posedge clk);
        chk8("link set", {5'h00, link}, 8'h07);
        for (int i = 0; i < 6; i += 2) wr(tcr_pkg::IDX_SC[i], 8'h00);
        repeat (2) @(posedge clk);
        chk8("link clear", {5'h00, link}, 8'h00);
        wb(1'b1, tcr_pkg::IDX_LO[0], 8'h11, 4'hE, junk);
        rd("lane ignored", tcr_pkg::IDX_LO[0], 8'h5A);
        $display("test register table done");
        // Each edge mode sees one rising and one falling pin change
        exp_lo = 8'hC3;
        exp_hi = 8'h3C;
        for (int m = 1; m < 4; m++) begin
            wr(tcr_pkg::IDX_SC[3], {4'h0, m[1:0], 2'h0});
            for (int e = 0; e < 2; e++) begin
                cnt <= {8'hC0, 8'(m * 16 + e)};
                pin[3] <= ~pin[3];
                repeat (3) @(posedge clk);
                hit = pin[3] ? m[0] : m[1];
                if (hit) exp_lo = 8'(m * 16 + e);
                if (hit) exp_hi = 8'hC0;
                rd("capture low", tcr_pkg::IDX_LO[3], exp_lo);
                rd("capture high", tcr_pkg::IDX_HI[3], exp_hi);
                rd("capture flag", tcr_pkg::IDX_SC[3], {hit, 3'h0, m[1:0], 2'h0});
                wr(tcr_pkg::IDX_SC[3], {4'h0, m[1:0], 2'h0});
            end
        end
        wr(tcr_pkg::IDX_SC[0], 8'h20);
        wr(tcr_pkg::IDX_SC[1], 8'h0C);
        pin[1] <= 1'b1;
        repeat (3) @(posedge clk);
        pin[1] <= 1'b0;
        repeat (3) @(posedge clk);
        rd("linked odd flag", tcr_pkg::IDX_SC[1], 8'h0C);
        rd("linked odd value", tcr_pkg::IDX_LO[1], 8'h80);
        chk8("link pair0", {5'h00, link}, 8'h01);
        wr(tcr_pkg::IDX_SC[0], 8'h00);
        wr(tcr_pkg::IDX_IRQ_STATUS, 8'h3F);
        $display("test capture modes done");
        wr(tcr_pkg::IDX_SC[1], 8'h04);
        cnt <= 16'h1234;
        pin[1] <= 1'b1;
        repeat (3) @(posedge clk);
        rd("irq status", tcr_pkg::IDX_IRQ_STATUS, 8'h02);
        chk8("irq masked", {7'h00, irq}, 8'h00);
        pin[1] <= 1'b0;
        repeat (2) @(posedge clk);
        cnt <= 16'h5678;
        pin[1] <= 1'b1;
        repeat (3) @(posedge clk);
        rd("recapture low", tcr_pkg::IDX_LO[1], 8'h78);
        rd("flag kept", tcr_pkg::IDX_SC[1], 8'h84);
        wr(tcr_pkg::IDX_IRQ_MASK, 8'h02);
        repeat (3) @(posedge clk);
        chk8("irq unmasked", {7'h00, irq}, 8'h01);
        wr(tcr_pkg::IDX_SC[1], 8'h04);
        rd("flag cleared", tcr_pkg::IDX_SC[1], 8'h04);
        wr(tcr_pkg::IDX_IRQ_STATUS, 8'h02);
        repeat (3) @(posedge clk);
        chk8("irq cleared", {7'h00, irq}, 8'h00);
        $display("test interrupt done");
        for (int s = 0; s < 7; s++) begin
            wr(tcr_pkg::IDX_MAIN_SC, 8'(s));
            repeat (4) @(posedge clk);
            count_ticks(128, 1'b0, n);
            chkc("tick count", 128 >> s, n);
        end
        wr(tcr_pkg::IDX_MAIN_SC, 8'h00);
        ce <= 1'b0;
        repeat (2) @(posedge clk);
        count_ticks(16, 1'b0, n);
        chkc("frozen tick count", 0, n);
        ce <= 1'b1;
        wr(tcr_pkg::IDX_MAIN_SC, 8'h07);
        repeat (4) @(posedge clk);
        count_ticks(80, 1'b1, n);
        chkc("external tick count", 8, n);
        $display("test prescaler done");
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        rd("sc second reset", tcr_pkg::IDX_SC[1], 8'h00);
        rd("select second reset", tcr_pkg::IDX_MAIN_SC, 8'h00);
        $display("test second reset done");
        wrap_up();
    end
endmodule
